// [rtl/dfs_defs.svh]
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

// Register byte offsets of the fault status bank.
`define DFS_A_COW_HI   16'h0548
`define DFS_A_COW_LO   16'h0549
`define DFS_A_BOW_HI   16'h054B
`define DFS_A_BOW_LO   16'h054C
`define DFS_A_BSW_HI   16'h054E
`define DFS_A_BSW_LO   16'h054F
`define DFS_A_MISC     16'h0550
`define DFS_A_PWR1     16'h0552
`define DFS_A_PWR2     16'h0553
`define DFS_A_PWR3     16'h0554
`define DFS_A_IRQ_STAT 16'h0560
`define DFS_A_IRQ_MASK 16'h0561

// Reset values.
`define DFS_RST_BYTE   8'h00
`define DFS_RST_CELLS  16'h0000
`define DFS_RST_GROUPS 7'h00

// Miscellaneous comparison status fields.
`define DFS_MISC_LPF   0
`define DFS_MISC_ABORT 1

// First power fault register fields.
`define DFS_P1_AOV     0
`define DFS_P1_AOSC    1
`define DFS_P1_DOV     2
`define DFS_P1_COV     3
`define DFS_P1_CUV     4
`define DFS_P1_REFOPEN 5
`define DFS_P1_DGOPEN  6
`define DFS_P1_CGOPEN  7

// Second power fault register fields.
`define DFS_P2_TOV     0
`define DFS_P2_TUV     1
`define DFS_P2_TOSC    2
`define DFS_P2_NEGUV   3
`define DFS_P2_HOSC    4
`define DFS_P2_BIST    6

// Third power fault register field.
`define DFS_P3_DRST    2

// Group index for interrupt status, mask and fault reset.
`define DFS_G_COW      0
`define DFS_G_BOW      1
`define DFS_G_BSW      2
`define DFS_G_MISC     3
`define DFS_G_PWR1     4
`define DFS_G_PWR2     5
`define DFS_G_PWR3     6

`endif

// [rtl/dfs_pkg.sv]
package dfs_pkg;

    // Whole state of the fault status bank.
    typedef struct packed {
        logic [15:0] cow;
        logic [15:0] bow;
        logic [15:0] bsw;
        logic [1:0]  misc;
        logic [7:0]  pwr1;
        logic [7:0]  pwr2;
        logic [7:0]  pwr3;
        logic [6:0]  irq_stat;
        logic [6:0]  irq_mask;
        logic [7:0]  rdata;
        logic        irq;
    } dfs_state_t;

endpackage

// [rtl/dfs_bank.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dfs_defs.svh"

// Functional notes
// - cell open-wire fails, cells 16..9 high, 8..1 low
// - fail when measurement below 4-bit threshold
// - balance open-wire fails per switch, 16 high
// - balance switch fails per switch, 16 high
// - misc bit 0 holds filter diagnostic fail
// - three ground/return open flags, bits 7..5
// - regulator fault flags at bits 4,3,2,0
// - analog oscillation flag bit 1, host ignores
// - supply self-test fail sets second register bit 6
// - reference and pump faults, bits 4..0
// - digital reset flag, third register bit 2
module dfs_bank
    import dfs_pkg::*;
#(
    parameter int CELLS  = 16,
    parameter int MEAS_W = 4
) (
    // Clock and reset.
    input  wire logic                          clock,
    input  wire logic                          rstn,
    // Register port.
    input  wire logic [15:0]                   addr,
    input  wire logic [7:0]                    write_data,
    input  wire logic                          write_strobe,
    input  wire logic                          read_strobe,
    output logic      [7:0]                    read_data,
    // Interrupt.
    output logic                               irq,
    // Cell open-wire comparison.
    input  wire logic                          ow_meas_valid,
    input  wire logic [CELLS-1:0][MEAS_W-1:0]  ow_meas,
    input  wire logic [3:0]                    open_wire_threshold,
    // Balancing diagnostics, one pulse with per-switch results.
    input  wire logic                          bal_ow_done,
    input  wire logic [CELLS-1:0]              balance_open_wire_fail_n,
    input  wire logic                          bal_sw_done,
    input  wire logic [CELLS-1:0]              balance_switch_fail_n,
    // Comparison and filter diagnostics.
    input  wire logic                          comp_adc_done,
    input  wire logic                          comp_adc_aborted,
    input  wire logic                          filter_diag_done,
    input  wire logic                          filter_diag_fail,
    // Supply and pin fault detectors.
    input  wire logic                          comm_ground_open,
    input  wire logic                          digital_ground_open,
    input  wire logic                          reference_return_open,
    input  wire logic                          comm_regulator_undervolt,
    input  wire logic                          comm_regulator_overvolt,
    input  wire logic                          digital_regulator_overvolt,
    input  wire logic                          analog_supply_oscillating,
    input  wire logic                          analog_regulator_overvolt,
    input  wire logic                          supply_selftest_done,
    input  wire logic                          supply_selftest_fail,
    input  wire logic                          high_reference_oscillating,
    input  wire logic                          negative_pump_undervolt,
    input  wire logic                          thermistor_ref_oscillating,
    input  wire logic                          thermistor_ref_undervolt,
    input  wire logic                          thermistor_ref_overvolt,
    // Digital reset causes.
    input  wire logic                          analog_uv_reset,
    input  wire logic                          shutdown_wake,
    input  wire logic                          hw_reset_event,
    // Fault reset, one bit per register group.
    input  wire logic [6:0]                    fault_reset
);

    dfs_state_t q;
    dfs_state_t d;

    logic [CELLS-1:0] cow_now;
    logic [15:0]      cow_set;
    logic [15:0]      bow_set;
    logic [15:0]      bsw_set;
    logic [1:0]       misc_set;
    logic [7:0]       p1_set;
    logic [7:0]       p2_set;
    logic [7:0]       p3_set;
    logic [6:0]       grp_ev;
    logic [6:0]       w1c;

    // Per-cell comparison of the open-wire measurement with the threshold.
    genvar gi;
    generate
        for (gi = 0; gi < CELLS; gi = gi + 1) begin : g_cell
            assign cow_now[gi] = ow_meas_valid &&
                (MEAS_W'(ow_meas[gi]) < MEAS_W'(open_wire_threshold));
        end
    endgenerate

    // Set terms for each register in register bit order.
    always_comb begin
        cow_set = `DFS_RST_CELLS;
        cow_set[CELLS-1:0] = cow_now;
        bow_set = `DFS_RST_CELLS;
        if (bal_ow_done) begin
            bow_set[CELLS-1:0] = balance_open_wire_fail_n;
        end
        bsw_set = `DFS_RST_CELLS;
        if (bal_sw_done) begin
            bsw_set[CELLS-1:0] = balance_switch_fail_n;
        end
        misc_set = 2'h0;
        misc_set[`DFS_MISC_ABORT] = comp_adc_done && comp_adc_aborted;
        misc_set[`DFS_MISC_LPF] = filter_diag_done && filter_diag_fail;
        p1_set = `DFS_RST_BYTE;
        p1_set[`DFS_P1_CGOPEN] = comm_ground_open;
        p1_set[`DFS_P1_DGOPEN] = digital_ground_open;
        p1_set[`DFS_P1_REFOPEN] = reference_return_open;
        p1_set[`DFS_P1_CUV] = comm_regulator_undervolt;
        p1_set[`DFS_P1_COV] = comm_regulator_overvolt;
        p1_set[`DFS_P1_DOV] = digital_regulator_overvolt;
        p1_set[`DFS_P1_AOSC] = analog_supply_oscillating;
        p1_set[`DFS_P1_AOV] = analog_regulator_overvolt;
        p2_set = `DFS_RST_BYTE;
        p2_set[`DFS_P2_BIST] = supply_selftest_done && supply_selftest_fail;
        p2_set[`DFS_P2_HOSC] = high_reference_oscillating;
        p2_set[`DFS_P2_NEGUV] = negative_pump_undervolt;
        p2_set[`DFS_P2_TOSC] = thermistor_ref_oscillating;
        p2_set[`DFS_P2_TUV] = thermistor_ref_undervolt;
        p2_set[`DFS_P2_TOV] = thermistor_ref_overvolt;
        p3_set = `DFS_RST_BYTE;
        p3_set[`DFS_P3_DRST] = analog_uv_reset || shutdown_wake ||
                               hw_reset_event;
    end

    // A group event is any fault bit that rises from clear to set.
    always_comb begin
        grp_ev = `DFS_RST_GROUPS;
        grp_ev[`DFS_G_COW] = |(cow_set & ~q.cow);
        grp_ev[`DFS_G_BOW] = |(bow_set & ~q.bow);
        grp_ev[`DFS_G_BSW] = |(bsw_set & ~q.bsw);
        grp_ev[`DFS_G_MISC] = |(misc_set & ~q.misc);
        grp_ev[`DFS_G_PWR1] = |(p1_set & ~q.pwr1);
        grp_ev[`DFS_G_PWR2] = |(p2_set & ~q.pwr2);
        grp_ev[`DFS_G_PWR3] = |(p3_set & ~q.pwr3);
    end

    // Write-one-to-clear strobe for the interrupt status register.
    always_comb begin
        w1c = `DFS_RST_GROUPS;
        if (write_strobe && (addr == `DFS_A_IRQ_STAT)) begin
            w1c = write_data[6:0];
        end
    end

    // Next state; a set in the same cycle as a clear wins.
    always_comb begin
        d = q;
        // Fault bits clear only by fault reset; host writes never reach them.
        d.cow = (fault_reset[`DFS_G_COW] ? `DFS_RST_CELLS : q.cow) | cow_set;
        d.bow = (fault_reset[`DFS_G_BOW] ? `DFS_RST_CELLS : q.bow) | bow_set;
        d.bsw = (fault_reset[`DFS_G_BSW] ? `DFS_RST_CELLS : q.bsw) | bsw_set;
        d.misc = (fault_reset[`DFS_G_MISC] ? 2'h0 : q.misc) | misc_set;
        d.pwr1 = (fault_reset[`DFS_G_PWR1] ? `DFS_RST_BYTE : q.pwr1) | p1_set;
        d.pwr2 = (fault_reset[`DFS_G_PWR2] ? `DFS_RST_BYTE : q.pwr2) | p2_set;
        d.pwr3 = (fault_reset[`DFS_G_PWR3] ? `DFS_RST_BYTE : q.pwr3) | p3_set;
        // Interrupt status is sticky and cleared by writing ones.
        d.irq_stat = (q.irq_stat & ~w1c) | grp_ev;
        if (write_strobe && (addr == `DFS_A_IRQ_MASK)) begin
            d.irq_mask = write_data[6:0];
        end
        // Read data stands for exactly one cycle after the strobe.
        d.rdata = `DFS_RST_BYTE;
        if (read_strobe) begin
            case (addr)
                `DFS_A_COW_HI:   d.rdata = q.cow[15:8];
                `DFS_A_COW_LO:   d.rdata = q.cow[7:0];
                `DFS_A_BOW_HI:   d.rdata = q.bow[15:8];
                `DFS_A_BOW_LO:   d.rdata = q.bow[7:0];
                `DFS_A_BSW_HI:   d.rdata = q.bsw[15:8];
                `DFS_A_BSW_LO:   d.rdata = q.bsw[7:0];
                `DFS_A_MISC:     d.rdata = {6'h00, q.misc};
                `DFS_A_PWR1:     d.rdata = q.pwr1;
                `DFS_A_PWR2:     d.rdata = q.pwr2;
                `DFS_A_PWR3:     d.rdata = q.pwr3;
                `DFS_A_IRQ_STAT: d.rdata = {1'b0, q.irq_stat};
                `DFS_A_IRQ_MASK: d.rdata = {1'b0, q.irq_mask};
                default:         d.rdata = `DFS_RST_BYTE;
            endcase
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // State register.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q.cow      <= `DFS_RST_CELLS;
            q.bow      <= `DFS_RST_CELLS;
            q.bsw      <= `DFS_RST_CELLS;
            q.misc     <= 2'h0;
            q.pwr1     <= `DFS_RST_BYTE;
            q.pwr2     <= `DFS_RST_BYTE;
            q.pwr3     <= `DFS_RST_BYTE;
            q.irq_stat <= `DFS_RST_GROUPS;
            q.irq_mask <= `DFS_RST_GROUPS;
            q.rdata    <= `DFS_RST_BYTE;
            q.irq      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register.
    assign read_data = q.rdata;
    assign irq       = q.irq;

    // Checks on the bank behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    property p_cow_fail;
        ow_meas_valid && (ow_meas[0] < MEAS_W'(open_wire_threshold)) |=> q.cow[0];
    endproperty
    a_cow_fail: assert property (p_cow_fail) else $error("open-wire fail not latched");

    property p_cow_read;
        read_strobe && (addr == `DFS_A_COW_HI) |=> read_data == $past(q.cow[15:8]);
    endproperty
    a_cow_read: assert property (p_cow_read) else $error("cell high read wrong");

    property p_hold;
        !fault_reset[`DFS_G_PWR1] |=> (q.pwr1 & $past(q.pwr1)) == $past(q.pwr1);
    endproperty
    a_hold: assert property (p_hold) else $error("power fault bit fell");

    property p_reserved;
        read_strobe && (addr == `DFS_A_MISC) |=> read_data[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_abort;
        comp_adc_done && comp_adc_aborted |=> q.misc[`DFS_MISC_ABORT];
    endproperty
    a_abort: assert property (p_abort) else $error("abort flag not set");

    property p_lpf;
        filter_diag_done && filter_diag_fail |=> q.misc[`DFS_MISC_LPF];
    endproperty
    a_lpf: assert property (p_lpf) else $error("filter fail not set");

    property p_ground;
        comm_ground_open |=> q.pwr1[`DFS_P1_CGOPEN] ##1
            (q.pwr1[`DFS_P1_CGOPEN] || $past(fault_reset[`DFS_G_PWR1]));
    endproperty
    a_ground: assert property (p_ground) else $error("ground open not latched");

    property p_bist;
        supply_selftest_done && supply_selftest_fail |=> q.pwr2[`DFS_P2_BIST];
    endproperty
    a_bist: assert property (p_bist) else $error("self-test fail not set");

    property p_drst;
        shutdown_wake || analog_uv_reset |=> q.pwr3[`DFS_P3_DRST];
    endproperty
    a_drst: assert property (p_drst) else $error("reset flag not set");

    property p_rdata_idle;
        !read_strobe |=> read_data == `DFS_RST_BYTE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    // Cell open-wire results: top cell, pass case and gating by the valid pulse.
    property p_cow_top;
        ow_meas_valid && (ow_meas[CELLS-1] < MEAS_W'(open_wire_threshold)) |=> q.cow[CELLS-1];
    endproperty
    a_cow_top: assert property (p_cow_top) else $error("top cell fail not latched");

    property p_cow_lo_read;
        read_strobe && (addr == `DFS_A_COW_LO) |=> read_data == $past(q.cow[7:0]);
    endproperty
    a_cow_lo_read: assert property (p_cow_lo_read) else $error("cell low read wrong");

    property p_cow_pass;
        ow_meas_valid && (ow_meas[0] >= MEAS_W'(open_wire_threshold)) && !q.cow[0] |=>
            !q.cow[0];
    endproperty
    a_cow_pass: assert property (p_cow_pass) else $error("passing cell flagged");

    property p_cow_gate;
        !ow_meas_valid && !fault_reset[`DFS_G_COW] |=> q.cow == $past(q.cow);
    endproperty
    a_cow_gate: assert property (p_cow_gate) else $error("cell bits moved idle");

    // Balance results read back and latch only on their done pulse.
    property p_bow_hi_read;
        read_strobe && (addr == `DFS_A_BOW_HI) |=> read_data == $past(q.bow[15:8]);
    endproperty
    a_bow_hi_read: assert property (p_bow_hi_read) else $error("balance high read wrong");

    property p_bow_lo_read;
        read_strobe && (addr == `DFS_A_BOW_LO) |=> read_data == $past(q.bow[7:0]);
    endproperty
    a_bow_lo_read: assert property (p_bow_lo_read) else $error("balance low read wrong");

    property p_bow_latch;
        bal_ow_done |=> (q.bow[CELLS-1:0] & $past(balance_open_wire_fail_n)) ==
            $past(balance_open_wire_fail_n);
    endproperty
    a_bow_latch: assert property (p_bow_latch) else $error("balance fail lost");

    property p_bow_idle;
        !bal_ow_done && !fault_reset[`DFS_G_BOW] |=> q.bow == $past(q.bow);
    endproperty
    a_bow_idle: assert property (p_bow_idle) else $error("balance bits moved idle");

    property p_bsw_hi_read;
        read_strobe && (addr == `DFS_A_BSW_HI) |=> read_data == $past(q.bsw[15:8]);
    endproperty
    a_bsw_hi_read: assert property (p_bsw_hi_read) else $error("switch high read wrong");

    property p_bsw_latch;
        bal_sw_done |=> (q.bsw[CELLS-1:0] & $past(balance_switch_fail_n)) ==
            $past(balance_switch_fail_n);
    endproperty
    a_bsw_latch: assert property (p_bsw_latch) else $error("switch fail lost");

    // Without an aborted comparison or a misc group clear, the abort flag holds.
    property p_abort_hold;
        !(comp_adc_done && comp_adc_aborted) && !fault_reset[`DFS_G_MISC] |=>
            q.misc[`DFS_MISC_ABORT] == $past(q.misc[`DFS_MISC_ABORT]);
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort flag moved");

    // Supply and pin fault flags.
    property p_reg_ov;
        digital_regulator_overvolt |=> q.pwr1[`DFS_P1_DOV];
    endproperty
    a_reg_ov: assert property (p_reg_ov) else $error("regulator fault not set");

    property p_pwr1_read;
        read_strobe && (addr == `DFS_A_PWR1) |=> read_data == $past(q.pwr1);
    endproperty
    a_pwr1_read: assert property (p_pwr1_read) else $error("power one read wrong");

    property p_pwr2_read;
        read_strobe && (addr == `DFS_A_PWR2) |=> read_data == $past(q.pwr2);
    endproperty
    a_pwr2_read: assert property (p_pwr2_read) else $error("power two read wrong");

    property p_pump;
        negative_pump_undervolt |=> q.pwr2[`DFS_P2_NEGUV];
    endproperty
    a_pump: assert property (p_pump) else $error("pump fault not set");

    property p_hw_reset;
        hw_reset_event |=> q.pwr3[`DFS_P3_DRST];
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("hardware reset flag not set");

    // Only the reset flag may ever be set in the third power register.
    property p_pwr3_rsvd;
        q.pwr3 == (q.pwr3 & (8'h01 << `DFS_P3_DRST));
    endproperty
    a_pwr3_rsvd: assert property (p_pwr3_rsvd) else $error("reserved power bit set");

    // A fault in the cycle of its group clear survives; a lone clear empties.
    property p_set_wins;
        fault_reset[`DFS_G_PWR1] && comm_regulator_overvolt |=> q.pwr1[`DFS_P1_COV];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new fault");

    property p_fault_clear;
        fault_reset[`DFS_G_PWR2] && !(|p2_set) |=> q.pwr2 == `DFS_RST_BYTE;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault reset ignored");

    // Interrupt line follows the registered status and mask.
    property p_irq_level;
        irq == |(q.irq_stat & q.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_w1c;
        write_strobe && (addr == `DFS_A_IRQ_STAT) && write_data[`DFS_G_PWR1] &&
            !grp_ev[`DFS_G_PWR1] |=> !q.irq_stat[`DFS_G_PWR1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("status bit not cleared");

endmodule
`default_nettype wire

// [test/dfs_bank_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dfs_defs.svh"

module dfs_bank_test
    import dfs_pkg::*;
;
    logic                  clock;
    logic                  rstn;
    logic [15:0]           addr;
    logic [7:0]            write_data;
    logic                  write_strobe;
    logic                  read_strobe;
    logic [7:0]            read_data;
    logic                  irq;
    logic                  ow_meas_valid;
    logic [15:0][3:0]      ow_meas;
    logic [3:0]            open_wire_threshold;
    logic                  bal_ow_done;
    logic                  bal_sw_done;
    logic [15:0]           bal_ow_v;
    logic [15:0]           bal_sw_v;
    logic [3:0]            misc_in;
    logic [15:0]           pwr_in;
    logic                  sst_done;
    logic [2:0]            rst_cause;
    logic [6:0]            fault_reset;
    logic [7:0]            exp_q[$];
    logic                  rd_flag;
    logic [15:0][3:0]      meas;
    logic [3:0]            thr;
    logic [15:0]           expv;
    logic [15:0]           v;
    logic [15:0]           w;
    integer                seed;
    int                    fails;
    int                    cmp_count;
    int                    cyc;

    dfs_bank i_dut (
        .clock(clock), .rstn(rstn), .addr(addr), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .irq(irq), .ow_meas_valid(ow_meas_valid), .ow_meas(ow_meas),
        .open_wire_threshold(open_wire_threshold), .bal_ow_done(bal_ow_done),
        .balance_open_wire_fail_n(bal_ow_v), .bal_sw_done(bal_sw_done),
        .balance_switch_fail_n(bal_sw_v), .comp_adc_done(misc_in[3]),
        .comp_adc_aborted(misc_in[2]), .filter_diag_done(misc_in[1]),
        .filter_diag_fail(misc_in[0]), .comm_ground_open(pwr_in[7]),
        .digital_ground_open(pwr_in[6]), .reference_return_open(pwr_in[5]),
        .comm_regulator_undervolt(pwr_in[4]), .comm_regulator_overvolt(pwr_in[3]),
        .digital_regulator_overvolt(pwr_in[2]), .analog_supply_oscillating(pwr_in[1]),
        .analog_regulator_overvolt(pwr_in[0]), .supply_selftest_done(sst_done),
        .supply_selftest_fail(pwr_in[14]), .high_reference_oscillating(pwr_in[12]),
        .negative_pump_undervolt(pwr_in[11]), .thermistor_ref_oscillating(pwr_in[10]),
        .thermistor_ref_undervolt(pwr_in[9]), .thermistor_ref_overvolt(pwr_in[8]),
        .analog_uv_reset(rst_cause[0]), .shutdown_wake(rst_cause[1]),
        .hw_reset_event(rst_cause[2]), .fault_reset(fault_reset)
    );

    // Free-running 50 MHz clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Compares one byte and counts the outcome.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: read data %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one flag and counts the outcome.
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: irq %b expected %b", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // One-cycle register read; the expected byte is queued for the monitor.
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        read_strobe <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        read_strobe <= 1'b0;
    endtask

    // Pulses the fault reset of one group.
    task automatic clr(input int g);
        @(posedge clock);
        fault_reset <= 7'h01 << g;
        @(posedge clock);
        fault_reset <= 7'h00;
    endtask

    // Raises one supply or pin fault for a single cycle.
    task automatic pls_pwr(input int i);
        @(posedge clock);
        pwr_in <= 16'h0001 << i;
        sst_done <= (i == 14);
        @(posedge clock);
        pwr_in <= 16'h0000;
        sst_done <= 1'b0;
    endtask

    // Pulses the comparison and filter diagnostic inputs.
    task automatic pls_misc(input logic [3:0] m);
        @(posedge clock);
        misc_in <= m;
        @(posedge clock);
        misc_in <= 4'h0;
    endtask

    // Read data stand only in the cycle after a read strobe, else zero.
    always @(posedge clock) rd_flag <= read_strobe;
    always @(negedge clock) begin
        if (rstn && rd_flag) begin
            chk_byte(read_data, exp_q.pop_front());
        end else if (rstn) begin
            chk_byte(read_data, 8'h00);
        end
    end

    // Cuts a hung run short.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        seed = 32'h6265383E;
        {rstn, addr, write_data, write_strobe, read_strobe} = '0;
        {ow_meas_valid, ow_meas, open_wire_threshold, bal_ow_done, bal_sw_done} = '0;
        {bal_ow_v, bal_sw_v, misc_in, pwr_in, sst_done, rst_cause, fault_reset} = '0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        // Every register comes out of reset clear; unmapped places read zero.
        for (int a = 16'h0548; a <= 16'h0562; a++) rd(a[15:0], 8'h00);
        // Random measurements against random thresholds, zero threshold first.
        for (int it = 0; it < 4; it++) begin
            thr = (it == 0) ? 4'h0 : 4'($random(seed));
            for (int c = 0; c < 16; c++) meas[c] = 4'($random(seed));
            for (int c = 0; c < 16; c++) expv[c] = (meas[c] < thr);
            @(posedge clock);
            ow_meas <= meas;
            open_wire_threshold <= thr;
            ow_meas_valid <= 1'b1;
            @(posedge clock);
            ow_meas_valid <= 1'b0;
            ow_meas <= ~meas;
            rd(`DFS_A_COW_HI, expv[15:8]);
            rd(`DFS_A_COW_LO, expv[7:0]);
            clr(0);
        end
        // Balance results latch on the done pulse only.
        for (int it = 0; it < 3; it++) begin
            v = 16'($random(seed));
            w = 16'($random(seed));
            @(posedge clock);
            {bal_ow_v, bal_sw_v, bal_ow_done, bal_sw_done} <= {v, w, 2'b11};
            @(posedge clock);
            {bal_ow_v, bal_sw_v, bal_ow_done, bal_sw_done} <= {~v, ~w, 2'b00};
            rd(`DFS_A_BOW_HI, v[15:8]);
            rd(`DFS_A_BOW_LO, v[7:0]);
            rd(`DFS_A_BSW_HI, w[15:8]);
            rd(`DFS_A_BSW_LO, w[7:0]);
            clr(1);
            clr(2);
        end
        pls_misc(4'b1000);
        rd(`DFS_A_MISC, 8'h00);
        pls_misc(4'b1100);
        rd(`DFS_A_MISC, 8'h02);
        pls_misc(4'b0011);
        rd(`DFS_A_MISC, 8'h03);
        clr(3);
        // Each supply and pin fault lands on its own bit alone.
        for (int i = 0; i < 16; i++) begin
            if (i != 13 && i != 15) begin
                pls_pwr(i);
                rd(i < 8 ? `DFS_A_PWR1 : `DFS_A_PWR2, 8'h01 << (i % 8));
                clr(i < 8 ? 4 : 5);
            end
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            rst_cause <= 3'b001 << i;
            @(posedge clock);
            rst_cause <= 3'b000;
            rd(`DFS_A_PWR3, 8'h04);
            clr(6);
        end
        // Writes to fault registers change nothing; bits stay latched.
        pls_pwr(7);
        wr(`DFS_A_PWR1, 8'h00);
        wr(`DFS_A_PWR2, 8'hFF);
        rd(`DFS_A_PWR1, 8'h80);
        rd(`DFS_A_PWR2, 8'h00);
        clr(4);
        // Interrupt: clear status, raise, mask, clear by writing one.
        wr(`DFS_A_IRQ_STAT, 8'h7F);
        rd(`DFS_A_IRQ_STAT, 8'h00);
        pls_pwr(6);
        @(negedge clock) chk_bit(irq, 1'b0);
        wr(`DFS_A_IRQ_MASK, 8'h10);
        @(negedge clock) chk_bit(irq, 1'b1);
        rd(`DFS_A_IRQ_MASK, 8'h10);
        rd(`DFS_A_IRQ_STAT, 8'h10);
        wr(`DFS_A_IRQ_STAT, 8'h10);
        @(negedge clock) chk_bit(irq, 1'b0);
        rd(`DFS_A_PWR1, 8'h40);
        // A fault raised in the cycle of its group clear stays; older bits go.
        @(posedge clock);
        pwr_in <= 16'h0008;
        fault_reset <= 7'h10;
        @(posedge clock);
        pwr_in <= 16'h0000;
        fault_reset <= 7'h00;
        rd(`DFS_A_PWR1, 8'h08);
        clr(4);
        // A second reset in mid-run clears every latched bit.
        pls_pwr(0);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(`DFS_A_PWR1, 8'h00);
        rd(`DFS_A_IRQ_MASK, 8'h00);
        repeat (3) @(posedge clock);
        complete_run();
    end
endmodule

`default_nettype wire
